// *** design/emc_pkg.sv ***
// package: register map, field positions, limits and states of the mac control block
package emc_pkg;
  localparam int AW = 18;
  localparam logic [17:0] OFF_CTRL = 18'h0_0000;
  localparam logic [17:0] OFF_DMA = 18'h0_0004;
  localparam logic [17:0] OFF_TXCTL = 18'h0_0008;
  localparam logic [17:0] OFF_PTV = 18'h0_000c;
  localparam logic [17:0] OFF_MAC1 = 18'h0_0010;
  localparam logic [17:0] OFF_MAC2 = 18'h0_0014;
  localparam logic [17:0] OFF_MAXF = 18'h0_0018;
  localparam logic [17:0] OFF_HDX = 18'h0_001c;
  localparam logic [17:0] OFF_FIFO = 18'h0_0020;
  localparam logic [17:0] OFF_XTR = 18'h0_0024;
  localparam logic [17:0] OFF_CARRY_REGISTER_1 = 18'h0_0028;
  localparam logic [17:0] OFF_CARRY_REGISTER_2 = 18'h0_002c;
  localparam logic [17:0] OFF_EVT = 18'h0_0030;
  localparam logic [17:0] OFF_RING = 18'h0_0034;
  localparam logic [17:0] OFF_CNT0 = 18'h0_0040;
  localparam logic [17:0] OFF_PRE_LO = 18'h0_0050;
  localparam logic [17:0] OFF_PRE_HI = 18'h0_0054;
  localparam logic [17:0] OFF_RXQ_PTR = 18'h2_4c44;
  // controller_config fields
  localparam int B_SPD100 = 0;
  localparam int B_RMII = 1;
  localparam int B_GMII = 2;
  localparam int B_TBI = 3;
  localparam int B_RPM = 4;
  localparam int B_CLEAR_COUNTERS = 5;
  localparam int B_AUTO_ZERO = 6;
  // dma_control, tx_control, mac_config and extract fields
  localparam int B_GTS = 0;
  localparam int B_TOD = 1;
  localparam int B_PAUSE = 0;
  localparam int B_SCHED = 1;
  localparam int B_HALF_DUPLEX_BACKPRESSURE = 3;
  localparam int B_TXFLOW = 0;
  localparam int B_RXFLOW = 1;
  localparam int B_FDX = 0;
  localparam int B_PREEN = 1;
  localparam int B_CRC_APPEND = 2;
  localparam int B_HUGE = 26;
  localparam int B_XOFF = 2;
  localparam logic [31:0] REG_RST = 32'h0000_0000;
  localparam logic [15:0] MAXF_RST = 16'h0600;
  localparam logic [15:0] MAXF_MIN = 16'h0040;
  localparam logic [15:0] MAXF_MAX = 16'h2580;
  localparam logic [15:0] OVR_PLAIN = 16'h05ee;
  localparam logic [15:0] OVR_VLAN = 16'h05f2;
  localparam logic [16:0] BYTE_CAP = 17'h0_ffff;
  localparam int PRE_BYTES = 7;
  localparam logic [1:0] SCHED_PRIO = 2'h1;
  localparam logic [1:0] XTR_OFF = 2'h1;
  localparam logic [1:0] XTR_L2 = 2'h2;
  localparam logic [1:0] XTR_L3 = 2'h3;
  typedef enum logic [1:0] {
    EMC_P_IDLE = 2'b00,
    EMC_P_WAIT = 2'b01,
    EMC_P_SEND = 2'b11
  } emc_pause_t;
endpackage : emc_pkg

// *** design/emc_top.sv ***
// mac configuration and control block with avalon-mm register slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
module emc_top #(
  parameter int RINGS = 8,
  parameter bit HAS_RMII = 1'b1
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic link_clk_in,
  input wire logic lk_frame_done_in,
  input wire logic lk_frame_rx_in,
  input wire logic [15:0] lk_frame_len_in,
  input wire logic lk_frame_ok_in,
  input wire logic lk_frame_abort_in,
  input wire logic lk_frame_vlan_in,
  input wire logic lk_phantom_in,
  input wire logic [7:0] lk_phantom_bytes_in,
  input wire logic lk_tx_busy_in,
  input wire logic lk_rx_pause_in,
  input wire logic lk_pause_done_in,
  input wire logic lk_pre_valid_in,
  input wire logic [2:0] lk_pre_len_in,
  input wire logic [55:0] lk_pre_data_in,
  input wire logic [15:0] lk_l2_end_in,
  input wire logic [15:0] lk_l3_end_in,
  input wire logic [RINGS-1:0] ring_ready_in,
  output logic [6:0] if_mode_out,
  output logic [5:0] mac_mode_out,
  output logic [7:0] fifo_gap_cycles_out,
  output logic [5:0] collision_window_out,
  output logic [15:0] max_frame_length_out,
  output logic bd_fetch_out,
  output logic [2:0] bd_fetch_ring_out,
  output logic ring_grant_valid_out,
  output logic [2:0] ring_grant_out,
  output logic data_hold_out,
  output logic pause_send_out,
  output logic [15:0] pause_time_out,
  output logic coalesce_tick_out,
  output logic extract_valid_out,
  output logic [15:0] extract_pos_out,
  output logic truncate_out,
  output logic bd_update_out
);
  localparam int LW = 125;
  logic [2:0] lck_q;
  logic [LW-1:0] ls1_q, ls2_q;
  logic fall;
  logic l_done, l_rx, l_ok, l_abort, l_vlan, l_ph, l_busy, l_rxp, l_pdone, l_pv;
  logic [15:0] l_len, l_l2, l_l3;
  logic [7:0] l_phb;
  logic [2:0] l_plen;
  logic [55:0] l_pdata;
  logic wreq_q, wr_go, rd_cap;
  logic [31:0] rdata_d, rdata_q, wd;
  logic [6:0] ctrl_q;
  logic gts_q, preq_q, half_duplex_backpressure_q, fdx_q, preen_q, crc_append_q, huge_q, evt_q, send_q;
  logic [1:0] sched_q, flow_q, xctl_q, carry_register_2_q;
  logic carry_register_1_q;
  logic [15:0] ptv_q, maxf_q, maxf_w;
  logic [5:0] cwin_q;
  logic [7:0] ipg_q, xoff_q, ring_en_q;
  logic [31:0] rxq_q;
  logic [55:0] pre_q, pre_d;
  logic clr, fev, trunc;
  logic [2:0] ovf;
  logic [31:0] cnt_q [3];
  logic [31:0] inc [3];
  logic [16:0] ph_q, bsum;
  emc_pkg::emc_pause_t pst_q, pst_d;
  logic [2:0] gsel;
  logic gany;
  logic tick_q, fetch_q, gv_q, hold_q, trunc_q, bdu_q, xv_q;
  logic [2:0] g_q;
  logic [15:0] xpos_q;

  // link clock and its data share one synchroniser depth; data is taken at the
  // link falling edge, half a link period after the far side changed it
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lck_q <= '0;
      ls1_q <= '0;
      ls2_q <= '0;
    end else begin
      lck_q <= {lck_q[1:0], link_clk_in};
      ls1_q <= {lk_frame_done_in, lk_frame_rx_in, lk_frame_len_in, lk_frame_ok_in, lk_frame_abort_in,
                lk_frame_vlan_in, lk_phantom_in, lk_phantom_bytes_in, lk_tx_busy_in, lk_rx_pause_in,
                lk_pause_done_in, lk_pre_valid_in, lk_pre_len_in, lk_pre_data_in, lk_l2_end_in, lk_l3_end_in};
      ls2_q <= ls1_q;
    end
  end
  assign fall = lck_q[2] & ~lck_q[1];
  assign {l_done, l_rx, l_len, l_ok, l_abort, l_vlan, l_ph, l_phb, l_busy, l_rxp,
          l_pdone, l_pv, l_plen, l_pdata, l_l2, l_l3} = ls2_q;

  // one wait state: request seen, then waitrequest drops for the taking edge
  assign wr_go = avs_write_in & ~wreq_q;
  assign rd_cap = avs_read_in & wreq_q;
  assign wd = avs_writedata_in;
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wreq_q <= 1'b1;
      rdata_q <= '0;
    end else begin
      wreq_q <= ~((avs_read_in | avs_write_in) & wreq_q);
      if (rd_cap) begin
        rdata_q <= rdata_d;
      end
    end
  end
  assign avs_waitrequest_out = wreq_q;
  assign avs_readdata_out = rdata_q;

  always_comb begin
    rdata_d = '0;
    unique case (avs_address_in)
      emc_pkg::OFF_CTRL: rdata_d = {25'h000_0000, ctrl_q};
      emc_pkg::OFF_DMA: rdata_d = {31'h0000_0000, gts_q};
      emc_pkg::OFF_TXCTL: rdata_d = {28'h000_0000, half_duplex_backpressure_q, sched_q, preq_q};
      emc_pkg::OFF_PTV: rdata_d = {16'h0000, ptv_q};
      emc_pkg::OFF_MAC1: rdata_d = {30'h0000_0000, flow_q};
      emc_pkg::OFF_MAC2: rdata_d = {5'h00, huge_q, 23'h00_0000, crc_append_q, preen_q, fdx_q};
      emc_pkg::OFF_MAXF: rdata_d = {16'h0000, maxf_q};
      emc_pkg::OFF_HDX: rdata_d = {26'h000_0000, cwin_q};
      emc_pkg::OFF_FIFO: rdata_d = {24'h00_0000, ipg_q};
      emc_pkg::OFF_XTR: rdata_d = {22'h00_0000, xoff_q, xctl_q};
      emc_pkg::OFF_CARRY_REGISTER_1: rdata_d = {31'h0000_0000, carry_register_1_q};
      emc_pkg::OFF_CARRY_REGISTER_2: rdata_d = {30'h0000_0000, carry_register_2_q};
      emc_pkg::OFF_EVT: rdata_d = {31'h0000_0000, evt_q};
      emc_pkg::OFF_RING: rdata_d = {24'h00_0000, ring_en_q};
      emc_pkg::OFF_CNT0: rdata_d = cnt_q[0];
      emc_pkg::OFF_CNT0 + 18'h0_0004: rdata_d = cnt_q[1];
      emc_pkg::OFF_CNT0 + 18'h0_0008: rdata_d = cnt_q[2];
      emc_pkg::OFF_PRE_LO: rdata_d = pre_q[31:0];
      emc_pkg::OFF_PRE_HI: rdata_d = {8'h00, pre_q[55:32]};
      emc_pkg::OFF_RXQ_PTR: rdata_d = rxq_q;
      default: rdata_d = '0;
    endcase
  end

  assign clr = wr_go & (avs_address_in == emc_pkg::OFF_CTRL) & wd[emc_pkg::B_CLEAR_COUNTERS];
  // writes outside the legal frame length range are pulled to the nearest bound
  assign maxf_w = (wd[15:0] < emc_pkg::MAXF_MIN) ? emc_pkg::MAXF_MIN :
                  (wd[15:0] > emc_pkg::MAXF_MAX) ? emc_pkg::MAXF_MAX : wd[15:0];

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_q <= emc_pkg::REG_RST[6:0];
      gts_q <= 1'b0;
      sched_q <= emc_pkg::REG_RST[1:0];
      half_duplex_backpressure_q <= 1'b0;
      ptv_q <= emc_pkg::REG_RST[15:0];
      flow_q <= emc_pkg::REG_RST[1:0];
      {huge_q, crc_append_q, preen_q, fdx_q} <= '0;
      maxf_q <= emc_pkg::MAXF_RST;
      cwin_q <= emc_pkg::REG_RST[5:0];
      ipg_q <= emc_pkg::REG_RST[7:0];
      {xoff_q, xctl_q} <= '0;
      ring_en_q <= emc_pkg::REG_RST[7:0];
      rxq_q <= emc_pkg::REG_RST;
    end else if (wr_go) begin
      unique case (avs_address_in)
        emc_pkg::OFF_CTRL: begin
          ctrl_q <= wd[6:0] & ~7'h20;
          ctrl_q[emc_pkg::B_RMII] <= wd[emc_pkg::B_RMII] & ~wd[emc_pkg::B_RPM] & HAS_RMII;
        end
        emc_pkg::OFF_DMA: gts_q <= wd[emc_pkg::B_GTS];
        emc_pkg::OFF_TXCTL: begin
          sched_q <= wd[emc_pkg::B_SCHED +: 2];
          half_duplex_backpressure_q <= wd[emc_pkg::B_HALF_DUPLEX_BACKPRESSURE];
        end
        emc_pkg::OFF_PTV: ptv_q <= wd[15:0];
        emc_pkg::OFF_MAC1: flow_q <= wd[1:0];
        emc_pkg::OFF_MAC2: begin
          {crc_append_q, preen_q, fdx_q} <= wd[2:0];
          huge_q <= wd[emc_pkg::B_HUGE];
        end
        emc_pkg::OFF_MAXF: maxf_q <= maxf_w;
        emc_pkg::OFF_HDX: cwin_q <= wd[5:0];
        emc_pkg::OFF_FIFO: ipg_q <= wd[7:0];
        emc_pkg::OFF_XTR: {xoff_q, xctl_q} <= wd[9:0];
        emc_pkg::OFF_RING: ring_en_q <= wd[7:0];
        emc_pkg::OFF_RXQ_PTR: rxq_q <= wd;
        default: ;
      endcase
    end
  end

  // pause request: software sets, hardware clears after the pause frame; a new
  // set in the clearing cycle wins
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      preq_q <= 1'b0;
      evt_q <= 1'b0;
      pst_q <= emc_pkg::EMC_P_IDLE;
      send_q <= 1'b0;
    end else begin
      pst_q <= pst_d;
      send_q <= (pst_d == emc_pkg::EMC_P_SEND);
      if (wr_go && avs_address_in == emc_pkg::OFF_TXCTL && wd[emc_pkg::B_PAUSE]) begin
        preq_q <= 1'b1;
      end else if (pst_q == emc_pkg::EMC_P_SEND && pst_d == emc_pkg::EMC_P_IDLE) begin
        preq_q <= 1'b0;
      end
      if (pst_q == emc_pkg::EMC_P_SEND && pst_d == emc_pkg::EMC_P_IDLE) begin
        evt_q <= 1'b1;
      end else if (wr_go && avs_address_in == emc_pkg::OFF_EVT && wd[0]) begin
        evt_q <= 1'b0;
      end
    end
  end

  // neither graceful stop nor a received pause holds back the pause frame
  always_comb begin
    pst_d = pst_q;
    unique case (pst_q)
      emc_pkg::EMC_P_IDLE: if (preq_q) pst_d = emc_pkg::EMC_P_WAIT;
      emc_pkg::EMC_P_WAIT: if (!l_busy) pst_d = emc_pkg::EMC_P_SEND;
      emc_pkg::EMC_P_SEND: if (fall && l_pdone) pst_d = emc_pkg::EMC_P_IDLE;
      default: pst_d = emc_pkg::EMC_P_IDLE;
    endcase
  end

  // statistics: frame counter, tx byte counter, tx oversize counter
  assign fev = fall & l_done;
  assign trunc = ~huge_q & (l_len > maxf_q);
  assign bsum = {1'b0, l_len} + ph_q;
  always_comb begin
    inc[0] = {31'h0000_0000, fev & ~l_abort & ~trunc};
    inc[1] = '0;
    if (fev && !l_rx && !l_abort) begin
      inc[1] = {16'h0000, (bsum > emc_pkg::BYTE_CAP) ? emc_pkg::BYTE_CAP[15:0] : bsum[15:0]};
    end
    inc[2] = {31'h0000_0000, fev & ~l_rx & ~l_abort & l_ok &
              (l_len > (l_vlan ? emc_pkg::OVR_VLAN : emc_pkg::OVR_PLAIN))};
  end

  for (genvar i = 0; i < 3; i++) begin : g_cnt
    logic [32:0] sum;
    logic zap;
    assign zap = rd_cap & ctrl_q[emc_pkg::B_AUTO_ZERO] &
                 (avs_address_in == emc_pkg::OFF_CNT0 + 18'(4 * i));
    assign sum = {1'b0, (zap ? 32'h0000_0000 : cnt_q[i])} + {1'b0, inc[i]};
    assign ovf[i] = sum[32];
    always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
        cnt_q[i] <= emc_pkg::REG_RST;
      end else if (clr) begin
        cnt_q[i] <= '0;
      end else if (wr_go && avs_address_in == emc_pkg::OFF_CNT0 + 18'(4 * i)) begin
        cnt_q[i] <= wd;
      end else begin
        cnt_q[i] <= sum[31:0];
      end
    end
  end

  // phantom preamble from back-pressure rides on the next transmitted frame
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ph_q <= '0;
      carry_register_1_q <= 1'b0;
      carry_register_2_q <= '0;
    end else begin
      if (fev && !l_rx) begin
        ph_q <= '0;
      end else if (fall && l_ph && half_duplex_backpressure_q && ph_q < emc_pkg::BYTE_CAP) begin
        ph_q <= ph_q + {9'h000, l_phb};
      end
      carry_register_1_q <= ovf[0] | (carry_register_1_q & ~clr &
                ~(wr_go && avs_address_in == emc_pkg::OFF_CARRY_REGISTER_1 && wd[0]));
      carry_register_2_q <= ovf[2:1] | (carry_register_2_q & {2{~clr}} &
                ~({2{wr_go && avs_address_in == emc_pkg::OFF_CARRY_REGISTER_2}} & wd[1:0]));
    end
  end

  // preamble capture, right aligned so missing leading bytes read as zero
  always_comb begin
    pre_d = '0;
    for (int b = 0; b < emc_pkg::PRE_BYTES; b++) begin
      if (b < int'(l_plen)) begin
        pre_d[8*b +: 8] = l_pdata[8*b +: 8];
      end
    end
  end
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_q <= '0;
    end else if (fall && l_pv && preen_q) begin
      pre_q <= pre_d;
    end
  end

  // lowest enabled ready ring wins in priority mode; other modes stay on ring 0
  always_comb begin
    gsel = '0;
    gany = 1'b0;
    if (sched_q == emc_pkg::SCHED_PRIO) begin
      for (int r = RINGS - 1; r >= 0; r--) begin
        if (ring_ready_in[r] && ring_en_q[r]) begin
          gsel = 3'(r);
          gany = 1'b1;
        end
      end
    end else begin
      gany = ring_ready_in[0] & ring_en_q[0];
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_q <= 1'b0;
      fetch_q <= 1'b0;
      gv_q <= 1'b0;
      g_q <= '0;
      hold_q <= 1'b0;
      {trunc_q, bdu_q} <= '0;
      xv_q <= 1'b0;
      xpos_q <= '0;
    end else begin
      tick_q <= ~tick_q;
      fetch_q <= wr_go & (avs_address_in == emc_pkg::OFF_DMA) & wd[emc_pkg::B_TOD];
      gv_q <= gany & ~hold_q;
      g_q <= gsel;
      hold_q <= (pst_d != emc_pkg::EMC_P_IDLE) | gts_q | l_rxp;
      trunc_q <= fev & trunc;
      bdu_q <= fev & (trunc | (~huge_q & ~l_rx & (l_len == maxf_q)));
      xv_q <= xctl_q != '0;
      unique case (xctl_q)
        emc_pkg::XTR_OFF: xpos_q <= {8'h00, xoff_q};
        emc_pkg::XTR_L2: xpos_q <= l_l2 + {8'h00, xoff_q};
        emc_pkg::XTR_L3: xpos_q <= l_l3 + {8'h00, xoff_q};
        default: xpos_q <= '0;
      endcase
    end
  end

  assign if_mode_out = ctrl_q;
  assign mac_mode_out = {huge_q, crc_append_q, preen_q, fdx_q, flow_q};
  assign fifo_gap_cycles_out = ipg_q;
  assign collision_window_out = cwin_q;
  assign max_frame_length_out = maxf_q;
  assign bd_fetch_out = fetch_q;
  assign bd_fetch_ring_out = 3'h0;
  assign ring_grant_valid_out = gv_q;
  assign ring_grant_out = g_q;
  assign data_hold_out = hold_q;
  assign pause_send_out = send_q;
  assign pause_time_out = ptv_q;
  assign coalesce_tick_out = tick_q;
  assign extract_valid_out = xv_q;
  assign extract_pos_out = xpos_q;
  assign truncate_out = trunc_q;
  assign bd_update_out = bdu_q;
endmodule : emc_top

// *** test/emc_phy_model.sv ***
// link partner: phy side, clock runs only while an event is sent
`timescale 1ns/10ps
module emc_phy_model (
  output logic link_clk_out,
  output logic done_out,
  output logic rx_out,
  output logic [15:0] len_out,
  output logic ok_out,
  output logic abort_out,
  output logic vlan_out,
  output logic ph_out,
  output logic [7:0] ph_bytes_out,
  output logic busy_out,
  output logic rx_pause_out,
  output logic pdone_out,
  output logic pre_valid_out,
  output logic [2:0] pre_len_out,
  output logic [55:0] pre_data_out,
  output logic [15:0] l2_end_out,
  output logic [15:0] l3_end_out
);
  initial begin
    {link_clk_out, done_out, rx_out, ok_out, abort_out, vlan_out, ph_out, busy_out} = 8'h00;
    {rx_pause_out, pdone_out, pre_valid_out, pre_len_out, pre_data_out} = '0;
    {len_out, ph_bytes_out, l2_end_out, l3_end_out} = '0;
  end
  // f is {fcs ok, abort, vlan}; released length and phantom byte fields show the inverse, not a stale value
  task automatic frame(input logic rx, input logic [15:0] len, input logic [2:0] f, input logic [7:0] ph);
    if (ph != 8'h00) begin
      #40 link_clk_out = 1'b1;
      {ph_out, ph_bytes_out} = {1'b1, ph};
      #40 link_clk_out = 1'b0;
    end
    #40 link_clk_out = 1'b1;
    {ph_out, ph_bytes_out} = {1'b0, ~ph};
    {done_out, rx_out, len_out, ok_out, abort_out, vlan_out} = {1'b1, rx, len, f};
    {pre_valid_out, pre_len_out, pre_data_out} = {rx, 3'h5, 56'hffff_5555_5555_d5};
    {l2_end_out, l3_end_out} = {16'h000e, 16'h0022};
    #40 link_clk_out = 1'b0;
    #40 link_clk_out = 1'b1;
    {done_out, pre_valid_out, len_out} = {2'b00, ~len};
    #40 link_clk_out = 1'b0;
  endtask : frame
  task automatic busy(input logic b);
    #40 link_clk_out = 1'b1;
    busy_out = b;
    #40 link_clk_out = 1'b0;
  endtask : busy
  task automatic pause_done();
    #40 link_clk_out = 1'b1;
    pdone_out = 1'b1;
    #40 link_clk_out = 1'b0;
    #40 link_clk_out = 1'b1;
    pdone_out = 1'b0;
    #40 link_clk_out = 1'b0;
  endtask : pause_done
endmodule : emc_phy_model

// *** test/emc_properties.sv ***
// checker: port-level properties of the mac control block
`timescale 1ns/10ps
module emc_checker #(
  parameter int RINGS = 8
) (
  input wire logic clock_in,
  input wire logic arst_n_in,
  input wire logic [17:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic avs_waitrequest_out,
  input wire logic [RINGS-1:0] ring_ready_in,
  input wire logic [6:0] if_mode_out,
  input wire logic [15:0] max_frame_length_out,
  input wire logic bd_fetch_out,
  input wire logic [2:0] bd_fetch_ring_out,
  input wire logic ring_grant_valid_out,
  input wire logic [2:0] ring_grant_out,
  input wire logic data_hold_out,
  input wire logic pause_send_out,
  input wire logic coalesce_tick_out,
  input wire logic truncate_out,
  input wire logic bd_update_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  logic [RINGS-1:0] ready_q;
  always_ff @(posedge clock_in) begin
    ready_q <= ring_ready_in;
  end
  a_wait_once: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer after request");
  a_answer_short: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low too long");
  a_tick_fall: assert property (coalesce_tick_out |=> !coalesce_tick_out)
    else $error("coalescing tick did not fall");
  a_tick_rise: assert property (!coalesce_tick_out |=> coalesce_tick_out)
    else $error("coalescing tick did not rise");
  a_fetch_cause: assert property (avs_write_in && !avs_waitrequest_out && avs_address_in == emc_pkg::OFF_DMA
    && avs_writedata_in[emc_pkg::B_TOD] |-> ##[1:2] bd_fetch_out) else $error("no descriptor fetch after request");
  a_fetch_ring0: assert property (bd_fetch_out |-> bd_fetch_ring_out == 3'h0 ##1 !bd_fetch_out)
    else $error("fetch not a ring zero pulse");
  a_trunc_update: assert property (truncate_out |-> bd_update_out ##1 !truncate_out)
    else $error("truncation without descriptor update");
  a_send_held: assert property (pause_send_out |-> data_hold_out)
    else $error("data frames not held while pause sent");
  a_send_after: assert property ($rose(pause_send_out) |-> $past(data_hold_out))
    else $error("pause sent without prior data hold");
  a_grant_hold: assert property (data_hold_out && $past(data_hold_out) |-> !ring_grant_valid_out)
    else $error("ring granted during hold");
  a_grant_ready: assert property (ring_grant_valid_out |-> ready_q[ring_grant_out])
    else $error("grant to a ring without a frame");
  a_maxf_range: assert property (max_frame_length_out >= emc_pkg::MAXF_MIN && max_frame_length_out <= emc_pkg::MAXF_MAX)
    else $error("max frame length out of range");
  a_rmii_rpm: assert property (if_mode_out[emc_pkg::B_RMII] |-> !if_mode_out[emc_pkg::B_RPM])
    else $error("reduced mode set with parallel mode");
  c_pause: cover property ($rose(pause_send_out));
  c_trunc: cover property (truncate_out);
  c_fetch: cover property (bd_fetch_out);
  c_grant: cover property (ring_grant_valid_out && ring_grant_out != 3'h0);
endmodule : emc_checker
bind emc_top emc_checker #(.RINGS(RINGS)) i_emc_checker (.*);

// *** test/emc_top_tb_top.sv ***
// testbench: registers, link events, pause and ring scheduling
`timescale 1ns/10ps
module emc_top_tb_top;
  logic clock_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [17:0] avs_address_in = 18'h0_0000;
  logic [31:0] avs_writedata_in = 32'h0000_0000;
  logic [7:0] ring_ready_in = 8'h00;
  logic [31:0] avs_readdata_out, r;
  logic avs_waitrequest_out, bd_fetch_out, ring_grant_valid_out, data_hold_out, pause_send_out;
  logic coalesce_tick_out, extract_valid_out, truncate_out, bd_update_out;
  logic [6:0] if_mode_out;
  logic [5:0] mac_mode_out, collision_window_out;
  logic [7:0] fifo_gap_cycles_out;
  logic [15:0] max_frame_length_out, pause_time_out, extract_pos_out;
  logic [2:0] bd_fetch_ring_out, ring_grant_out;
  wire link_clk_out, done_out, rx_out, ok_out, abort_out, vlan_out, ph_out, busy_out, rx_pause_out;
  wire pdone_out, pre_valid_out;
  wire [15:0] len_out, l2_end_out, l3_end_out;
  wire [7:0] ph_bytes_out;
  wire [2:0] pre_len_out;
  wire [55:0] pre_data_out;
  int fail_count = 0, num_checks = 0, seed = 3749;
  int n_trunc = 0, n_upd = 0, n_fetch = 0;
  logic [31:0] exp_q[$];
  emc_top i_emc_top (.*, .link_clk_in(link_clk_out), .lk_frame_done_in(done_out), .lk_frame_rx_in(rx_out),
    .lk_frame_len_in(len_out), .lk_frame_ok_in(ok_out), .lk_frame_abort_in(abort_out),
    .lk_frame_vlan_in(vlan_out), .lk_phantom_in(ph_out), .lk_phantom_bytes_in(ph_bytes_out),
    .lk_tx_busy_in(busy_out), .lk_rx_pause_in(rx_pause_out), .lk_pause_done_in(pdone_out),
    .lk_pre_valid_in(pre_valid_out), .lk_pre_len_in(pre_len_out), .lk_pre_data_in(pre_data_out),
    .lk_l2_end_in(l2_end_out), .lk_l3_end_in(l3_end_out));
  emc_phy_model i_emc_phy_model (.*);
  always #5 clock_in = ~clock_in;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  // request held until waitrequest is seen low, then one idle edge before the next
  task automatic bus(input logic wr, input logic [17:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_write_in <= wr;
    avs_read_in <= !wr;
    do begin
      @(posedge clock_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 100);
    if (n >= 100) check(32'h0000_0000, 32'h0000_0001);
    if (n >= 100) stop_test();
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clock_in);
  endtask : bus
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic fr(input logic rx, input logic [15:0] len, input logic [2:0] f, input logic [7:0] ph);
    i_emc_phy_model.frame(rx, len, f, ph);
    repeat (8) @(posedge clock_in);
  endtask : fr
  function automatic logic [3:0] low_ring(input logic [7:0] m);
    low_ring = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (m[i]) low_ring = {1'b1, 3'(i)};
    end
  endfunction : low_ring
  // read data taken only at the edge that ends the wait
  always @(posedge clock_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0) begin
      check(avs_readdata_out, exp_q.size() > 0 ? exp_q.pop_front() : ~avs_readdata_out);
    end
    if (truncate_out === 1'b1) n_trunc++;
    if (bd_update_out === 1'b1) n_upd++;
    if (bd_fetch_out === 1'b1) n_fetch++;
  end
  initial begin
    repeat (3) @(posedge clock_in);
    arst_n_in <= 1'b1;
    @(posedge clock_in);
    check({16'h0000, max_frame_length_out}, 32'h0000_0600);
    rd(emc_pkg::OFF_MAXF, 32'h0000_0600);
    rd(18'h0_0200, 32'h0000_0000);
    wr(emc_pkg::OFF_MAXF, 32'h0000_0010);
    rd(emc_pkg::OFF_MAXF, 32'h0000_0040);
    wr(emc_pkg::OFF_MAXF, 32'h0000_3000);
    rd(emc_pkg::OFF_MAXF, 32'h0000_2580);
    wr(emc_pkg::OFF_CTRL, 32'h0000_0072);
    rd(emc_pkg::OFF_CTRL, 32'h0000_0050);
    check({25'h0, if_mode_out}, 32'h0000_0050);
    wr(emc_pkg::OFF_CTRL, 32'h0000_0042);
    rd(emc_pkg::OFF_CTRL, 32'h0000_0042);
    wr(emc_pkg::OFF_MAC2, 32'h0000_0007);
    wr(emc_pkg::OFF_FIFO, 32'h0000_0007);
    wr(emc_pkg::OFF_MAC1, 32'h0000_0003);
    check({26'h0, mac_mode_out}, 32'h0000_001f);
    check({24'h0, fifo_gap_cycles_out}, 32'h0000_0007);
    wr(emc_pkg::OFF_HDX, 32'hffff_ffff);
    rd(emc_pkg::OFF_HDX, 32'h0000_003f);
    check({26'h0, collision_window_out}, 32'h0000_003f);
    // counters with auto zero set, phantom bytes need back-pressure mode
    wr(emc_pkg::OFF_TXCTL, 32'h0000_0008);
    fr(1'b0, 16'd1519, 3'b100, 8'h00);
    fr(1'b0, 16'd1522, 3'b101, 8'h00);
    fr(1'b0, 16'd1519, 3'b000, 8'h00);
    fr(1'b0, 16'd100, 3'b110, 8'h00);
    fr(1'b0, 16'd100, 3'b100, 8'h0a);
    rd(emc_pkg::OFF_CNT0, 32'h0000_0004);
    rd(emc_pkg::OFF_CNT0, 32'h0000_0000);
    rd(18'h0_0044, 32'h0000_123e);
    rd(18'h0_0048, 32'h0000_0001);
    wr(emc_pkg::OFF_CNT0, 32'hffff_ffff);
    fr(1'b0, 16'd100, 3'b100, 8'h00);
    rd(emc_pkg::OFF_CARRY_REGISTER_1, 32'h0000_0001);
    wr(emc_pkg::OFF_CARRY_REGISTER_1, 32'h0000_0001);
    rd(emc_pkg::OFF_CARRY_REGISTER_1, 32'h0000_0000);
    wr(emc_pkg::OFF_CNT0, 32'hffff_ffff);
    fr(1'b0, 16'd100, 3'b100, 8'h00);
    wr(emc_pkg::OFF_CTRL, 32'h0000_0022);
    rd(emc_pkg::OFF_CARRY_REGISTER_1, 32'h0000_0000);
    rd(18'h0_0044, 32'h0000_0000);
    // length limit with auto zero off
    wr(emc_pkg::OFF_MAXF, 32'h0000_0040);
    fr(1'b1, 16'h0041, 3'b100, 8'h00);
    fr(1'b0, 16'h0040, 3'b100, 8'h00);
    fr(1'b1, 16'h0040, 3'b100, 8'h00);
    wr(emc_pkg::OFF_MAC2, 32'h0400_0007);
    fr(1'b1, 16'h0080, 3'b100, 8'h00);
    rd(emc_pkg::OFF_CNT0, 32'h0000_0003);
    rd(emc_pkg::OFF_CNT0, 32'h0000_0003);
    check(n_trunc, 32'h0000_0001);
    check(n_upd, 32'h0000_0002);
    wr(emc_pkg::OFF_DMA, 32'h0000_0002);
    repeat (3) @(posedge clock_in);
    check(n_fetch, 32'h0000_0001);
    wr(emc_pkg::OFF_XTR, 32'h0000_0022);
    rd(emc_pkg::OFF_PRE_LO, 32'h5555_55d5);
    check(32'({extract_valid_out, extract_pos_out}), 32'h0001_0016);
    wr(emc_pkg::OFF_XTR, 32'h0000_0023);
    rd(emc_pkg::OFF_PRE_HI, 32'h0000_0055);
    check(32'({extract_valid_out, extract_pos_out}), 32'h0001_002a);
    // pause under graceful stop, frame in progress first
    wr(emc_pkg::OFF_PTV, 32'h0000_1234);
    wr(emc_pkg::OFF_DMA, 32'h0000_0001);
    i_emc_phy_model.busy(1'b1);
    repeat (4) @(posedge clock_in);
    wr(emc_pkg::OFF_TXCTL, 32'h0000_0001);
    repeat (4) @(posedge clock_in);
    check({data_hold_out, pause_send_out}, 32'h0000_0002);
    i_emc_phy_model.busy(1'b0);
    for (int i = 0; i < 50 && pause_send_out !== 1'b1; i++) @(posedge clock_in);
    check(pause_send_out, 32'h0000_0001);
    if (pause_send_out !== 1'b1) stop_test();
    check(pause_time_out, 32'h0000_1234);
    i_emc_phy_model.pause_done();
    repeat (6) @(posedge clock_in);
    rd(emc_pkg::OFF_TXCTL, 32'h0000_0000);
    rd(emc_pkg::OFF_EVT, 32'h0000_0001);
    wr(emc_pkg::OFF_EVT, 32'h0000_0001);
    rd(emc_pkg::OFF_EVT, 32'h0000_0000);
    wr(emc_pkg::OFF_DMA, 32'h0000_0000);
    // priority scheduling, rings 0 and 3 disabled
    wr(emc_pkg::OFF_TXCTL, 32'h0000_0002);
    wr(emc_pkg::OFF_RING, 32'h0000_00f6);
    for (int k = 0; k < 10; k++) begin
      r = $random(seed);
      ring_ready_in <= r[7:0];
      repeat (3) @(posedge clock_in);
      check({ring_grant_valid_out, ring_grant_out}, low_ring(r[7:0] & 8'hf6));
    end
    stop_test();
  end
endmodule : emc_top_tb_top
